// file: bench/mdc_modulus_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mdc_modulus_ctrl_properties
    import mdc_pkg::*;
(
    input wire logic        ref_clk_in,          // clk
    input wire logic        rst_in,              // rst
    input wire logic        wb_cyc_in,           // cyc
    input wire logic        wb_stb_in,           // stb
    input wire logic        wb_we_in,            // we
    input wire logic [7:0]  wb_adr_in,           // adr
    input wire logic [3:0]  wb_sel_in,           // sel
    input wire logic [31:0] wb_dat_in,           // wdat
    input wire logic [31:0] wb_dat_out,          // rdat
    input wire logic        wb_ack_out,          // ack
    input wire logic [63:0] capture_chan_in,     // cap
    input wire logic [31:0] pulse_acc_in,        // acc
    input wire logic        precision_tick_in,   // tick
    input wire logic        pulse_acc_clear_out, // clr
    input wire logic        irq_out              // irq
);
    wire [5:0] idx    = wb_adr_in[7:2];
    wire       is_ctl = idx == IDX_CONTROL[5:0];
    wire       is_flg = idx == IDX_FLAG[5:0];
    wire       rd_ack = wb_ack_out && !wb_we_in;
    // address and data still held by the master at the ack edge
    wire       wr_ctl = wb_ack_out && wb_we_in && wb_sel_in[0] && is_ctl;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    AST_ACK_RESP: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
        |=> wb_ack_out) else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack too long");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_out)
        |-> $past(wb_cyc_in && wb_stb_in)) else $error("ack unasked");
    AST_CTL_RD: assert property (rd_ack && is_ctl
        |-> wb_dat_out[4:3] == 2'b00) else $error("strobe bit reads one");
    AST_FLAG_RD: assert property (rd_ack && is_flg
        |-> {wb_dat_out[31:8], wb_dat_out[6:0]} == 31'h0)
        else $error("flag read junk");
    AST_CLR_PULSE: assert property (pulse_acc_clear_out
        |=> !pulse_acc_clear_out) else $error("clear too long");
    AST_CLR_CAUSE: assert property (pulse_acc_clear_out
        |-> $past(wr_ctl && wb_dat_in[4])) else $error("clear unasked");
    AST_NO_CLR: assert property (wr_ctl && !wb_dat_in[4]
        |=> !pulse_acc_clear_out) else $error("zero write latched");

    cover property (pulse_acc_clear_out);
    cover property (irq_out);
    cover property (rd_ack && is_flg && wb_dat_out[7]);
endmodule
bind mdc_modulus_ctrl mdc_modulus_ctrl_properties u_props (.*);
`default_nettype wire

// file: bench/test_modulus_down_counter_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_modulus_down_counter_ctrl
    import mdc_pkg::*;
;
    localparam logic [63:0] CAP = 64'h4444_3333_2222_1111;
    localparam logic [31:0] ACC = 32'hd4c3b2a1;
    logic        clk, rst, cyc, stb, we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wd, q;
    wire  [31:0] rdat;
    wire         ack, clr, irq;
    int          error_cnt, check_count, now, t_ack, clr_n;

    mdc_modulus_ctrl uut (.ref_clk_in(clk), .rst_in(rst), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(wd), .wb_dat_out(rdat), .wb_ack_out(ack),
        .capture_chan_in(CAP), .pulse_acc_in(ACC), .precision_tick_in(1'b0),
        .pulse_acc_clear_out(clr), .irq_out(irq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        now <= now + 1;
        if (clr === 1'b1) clr_n <= clr_n + 1;
    end

    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task wb(input logic w, input logic [7:0] i, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i[5:0], 2'b00};
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            error_cnt++;
            end_of_test;
        end
        q = rdat;
        t_ack = now;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] i, input logic [31:0] e);
        wb(1'b0, i, 32'h0);
        check($sformatf("reg %h", i), q, e);
    endtask

    task t_reset;
        rd(IDX_LOAD, 32'hffff);
        rd(IDX_COUNT, 32'hffff);
        rd(8'h00, 32'h0);
        wb(1'b1, IDX_LOAD, 32'h4);
        rd(IDX_LOAD, 32'h4);
    endtask
    // elapsed cycles from force-load to seeing the zero flag: 4 ticks
    task t_rate(input logic [1:0] s, input int div);
        int t0;
        int k;
        wb(1'b1, IDX_CONTROL, 32'h0);
        wb(1'b1, IDX_FLAG, 32'h80);
        wb(1'b1, IDX_CONTROL, {29'h0, 1'b1, s});
        wb(1'b1, IDX_CONTROL, {28'h0, 2'b11, s});
        t0 = t_ack;
        k = 0;
        q = 32'h0;
        while (q[7] !== 1'b1 && k < 40) begin
            wb(1'b0, IDX_FLAG, 32'h0);
            k++;
        end
        check("zero time", t_ack - t0 > 4 * div
              && t_ack - t0 < 4 * div + 5, 1'b1);
        if (q[7] !== 1'b1) end_of_test;
    endtask
    task t_stop;
        wb(1'b1, IDX_CONTROL, 32'h0);
        rd(IDX_COUNT, 32'hffff);
        wb(1'b1, IDX_CONTROL, 32'h8);
        rd(IDX_COUNT, 32'hffff);
        wb(1'b1, IDX_FLAG, 32'h0);
        rd(IDX_FLAG, 32'h80);
        wb(1'b1, IDX_FLAG, 32'h80);
        rd(IDX_FLAG, 32'h0);
        check("irq masked", irq, 1'b0);
        rd(IDX_IRQ_ST, 32'h1);
        rd(IDX_IRQ_ST, 32'h0);
        wb(1'b1, IDX_CONTROL, 32'hf);
        rd(IDX_COUNT, 32'hffff);
        wb(1'b1, IDX_CONTROL, 32'hf);
        rd(IDX_CONTROL, 32'h7);
        rd(IDX_COUNT, 32'h4);
        wb(1'b1, IDX_CONTROL, 32'h4);
        rd(IDX_COUNT, 32'h4);
    endtask
    task t_latch;
        wb(1'b1, IDX_CAPSYS, 32'h1);
        wb(1'b1, IDX_CONTROL, 32'h10);
        rd(IDX_HOLD0, 32'h0);
        wb(1'b1, IDX_CAPSYS, 32'h3);
        wb(1'b1, IDX_IRQ_MSK, 32'h2);
        wb(1'b1, IDX_CONTROL, 32'h0);
        check("clear count", clr_n, 0);
        wb(1'b1, IDX_CONTROL, 32'h10);
        for (int n = 0; n < NUM_CHAN; n++)
            rd(IDX_HOLD0 + 8'(n),
               {8'h0, ACC[8*n +: 8], CAP[16*n +: 16]});
        check("clear count", clr_n, 1);
        check("irq", irq, 1'b1);
        rd(IDX_IRQ_ST, 32'h2);
        rd(IDX_IRQ_MSK, 32'h2);
        check("irq", irq, 1'b0);
    endtask

    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h0;
        sel = 4'h3;
        wd = 32'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        for (int s = 0; s < 4; s++)
            t_rate(2'(s), (s == 0) ? 1 : 4 << (s - 1));
        t_stop;
        t_latch;
        end_of_test;
    end
endmodule
`default_nettype wire

// file: hw/mdc_modulus_ctrl.sv
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - force-latch in buffered latch mode copies channels and accumulators.
// - every forced latch clears the pulse accumulators that were latched.
// - writing zero to force-latch does nothing; it always reads zero.
// - force-load while enabled reloads count and resets the prescaler.
// - writing zero to force-load does nothing; it always reads zero.
// - while disabled the counter stops and count holds 0xffff.
// - prescale select 00,01,10,11 divides by 1,4,8,16 with precision off.
// - a new prescale rate takes effect only at the next reload.
// - flag bit 7 clears on write one, zero leaves it, always readable.
module mdc_modulus_ctrl
    import mdc_pkg::*;
(
    input  wire logic        ref_clk_in,      // bus clock, 125 MHz
    input  wire logic        rst_in,          // async reset, active high
    input  wire logic        wb_cyc_in,       // wishbone cycle
    input  wire logic        wb_stb_in,       // wishbone strobe
    input  wire logic        wb_we_in,        // wishbone write enable
    input  wire logic [7:0]  wb_adr_in,       // byte address
    input  wire logic [3:0]  wb_sel_in,       // byte lane selects
    input  wire logic [31:0] wb_dat_in,       // write data
    output logic      [31:0] wb_dat_out,      // read data
    output logic             wb_ack_out,      // wishbone acknowledge
    input  wire logic [63:0] capture_chan_in, // channels 0..3, 16 bit each
    input  wire logic [31:0] pulse_acc_in,    // accumulators 0..3, 8 bit each
    input  wire logic        precision_tick_in, // tick when precision on
    output logic             pulse_acc_clear_out, // clear accumulators
    output logic             irq_out          // level interrupt
);

    function automatic logic [3:0] presc_last(input logic [1:0] sel);
        case (sel)
            2'h0:    presc_last = PRESC_LAST_1;
            2'h1:    presc_last = PRESC_LAST_4;
            2'h2:    presc_last = PRESC_LAST_8;
            default: presc_last = PRESC_LAST_16;
        endcase
    endfunction

    // 8-bit registers sit in the low byte, upper bits read as zero
    function automatic logic [31:0] zext8(input logic [7:0] b);
        zext8 = {24'h000000, b};
    endfunction

    logic [7:0]  ctl_reg;
    logic [7:0]  capsys_reg;
    logic        flag_reg;
    logic [15:0] load_reg;
    logic [15:0] count_reg;
    logic [3:0]  presc_reg;
    logic [3:0]  presc_last_reg;
    logic [1:0]  irq_st_reg;
    logic [1:0]  irq_msk_reg;
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic        acc_clr_reg;
    logic        irq_reg;
    logic [15:0] hold_cap_reg [NUM_CHAN];
    logic [7:0]  hold_acc_reg [NUM_CHAN];

    // bus decode
    wire logic [7:0] idx      = {2'h0, wb_adr_in[7:ADDR_LSB]};
    wire logic       req      = wb_cyc_in & wb_stb_in;
    wire logic       acc_edge = req & ack_reg;
    wire logic       wr_lo    = acc_edge & wb_we_in & wb_sel_in[0];
    wire logic       wr_hi    = acc_edge & wb_we_in & wb_sel_in[1];
    wire logic       rd_edge  = acc_edge & ~wb_we_in;
    wire logic       sel_ctl  = (idx == IDX_CONTROL);
    wire logic       sel_flg  = (idx == IDX_FLAG);
    wire logic       sel_load = (idx == IDX_LOAD);
    wire logic       sel_cnt  = (idx == IDX_COUNT);
    wire logic       sel_cap  = (idx == IDX_CAPSYS);
    wire logic       sel_ist  = (idx == IDX_IRQ_ST);
    wire logic       sel_msk  = (idx == IDX_IRQ_MSK);
    wire logic       sel_hold = (idx[7:2] == IDX_HOLD0[7:2]);
    wire logic [1:0] hold_ch  = idx[1:0];

    // register write strobes and the status clear-on-read strobe
    wire logic       wr_ctl   = wr_lo & sel_ctl;
    wire logic       wr_flg   = wr_lo & sel_flg;
    wire logic       wr_cap   = wr_lo & sel_cap;
    wire logic       wr_msk   = wr_lo & sel_msk;
    wire logic       wr_ld_l  = wr_lo & sel_load;
    wire logic       wr_ld_h  = wr_hi & sel_load;
    wire logic       clr_ist  = rd_edge & sel_ist;

    // strobes decoded from the write data
    // enable is the stored bit: a write that sets enable and force-load
    // together only starts the counter, it does not reload it
    wire logic       enabled  = ctl_reg[CTL_ENABLE];
    wire logic [1:0] rate_sel = ctl_reg[CTL_PRESC_HI:CTL_PRESC_LO];
    wire logic       force_latch = wr_ctl & wb_dat_in[CTL_FORCE_LATCH]
                                 & capsys_reg[CAP_LATCH_MODE]
                                 & capsys_reg[CAP_BUFFER_EN];
    wire logic       force_load  = wr_ctl & wb_dat_in[CTL_FORCE_LOAD]
                                 & enabled;

    // prescaled tick; precision option bypasses the local divider
    // precision ticks arrive as one-cycle pulses on this clock
    wire logic       presc_wrap = (presc_reg == presc_last_reg);
    wire logic       presc_clr  = ~enabled | force_load | presc_wrap;
    wire logic [3:0] presc_inc  = presc_reg + 4'h1;
    wire logic       tick       = capsys_reg[CAP_PRECISION]
                                ? precision_tick_in : presc_wrap;
    wire logic       at_zero    = (count_reg == COUNT_ZERO);
    wire logic       auto_load  = enabled & tick & at_zero;
    wire logic       reload     = force_load | auto_load;
    // flag on the step from one to zero only; reload at zero never flags
    wire logic       hits_zero  = enabled & tick & ~force_load
                                & (count_reg == COUNT_ONE);

    wire logic [15:0] count_next =
        ~enabled  ? COUNT_PRESET :
        reload    ? load_reg :
        tick      ? count_reg - COUNT_ONE :
                    count_reg;

    // set wins over clear so a zero reached during the clearing write
    // is never lost
    wire logic       flag_clr  = wr_flg & wb_dat_in[FLG_ZERO];
    wire logic       flag_next = hits_zero | (flag_reg & ~flag_clr);

    wire logic [1:0] irq_evt     = {force_latch, hits_zero};
    wire logic [1:0] irq_st_next = irq_evt | (irq_st_reg & ~{2{clr_ist}});
    wire logic [1:0] irq_pend    = irq_st_next & irq_msk_reg;

    // read data, one word per register
    wire logic [7:0]  ctl_rd  = {5'h00, ctl_reg[CTL_ENABLE],
                                 rate_sel};
    wire logic [31:0] rd_ctl  = zext8(ctl_rd);
    wire logic [31:0] rd_flg  = zext8({flag_reg, 7'h00});
    wire logic [31:0] rd_cap  = zext8(capsys_reg);
    wire logic [31:0] rd_load = {16'h0000, load_reg};
    wire logic [31:0] rd_cnt  = {16'h0000, count_reg};
    wire logic [31:0] rd_irq  = {30'h0, irq_st_reg};
    wire logic [31:0] rd_msk  = {30'h0, irq_msk_reg};
    // holding word: accumulator above the captured count
    wire logic [31:0] rd_hold = {8'h00, hold_acc_reg[hold_ch],
                                 hold_cap_reg[hold_ch]};
    wire logic [31:0] rd_word =
        sel_ctl  ? rd_ctl  :
        sel_flg  ? rd_flg  :
        sel_load ? rd_load :
        sel_cnt  ? rd_cnt  :
        sel_cap  ? rd_cap  :
        sel_ist  ? rd_irq  :
        sel_msk  ? rd_msk  :
        sel_hold ? rd_hold :
                   WORD_ZERO;

    // bus slave: ack one cycle after the request, dropped the next cycle
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // read word sampled every cycle; the master takes it with ack
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dat_reg <= WORD_ZERO;
        end else begin
            dat_reg <= rd_word;
        end
    end

    // control and configuration registers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_reg <= BYTE_RESET;
        end else if (wr_ctl) begin
            // strobe bits are never stored
            ctl_reg[CTL_ENABLE] <= wb_dat_in[CTL_ENABLE];
            ctl_reg[CTL_PRESC_HI:CTL_PRESC_LO] <=
                wb_dat_in[CTL_PRESC_HI:CTL_PRESC_LO];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            capsys_reg <= BYTE_RESET;
        end else if (wr_cap) begin
            capsys_reg <= wb_dat_in[7:0];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_msk_reg <= IRQ_RESET;
        end else if (wr_msk) begin
            irq_msk_reg <= wb_dat_in[1:0];
        end
    end

    // load register, byte lanes written separately
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            load_reg[7:0] <= LOAD_RESET[7:0];
        end else if (wr_ld_l) begin
            load_reg[7:0] <= wb_dat_in[7:0];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            load_reg[15:8] <= LOAD_RESET[15:8];
        end else if (wr_ld_h) begin
            load_reg[15:8] <= wb_dat_in[15:8];
        end
    end

    // down-counter and prescaler
    // preset while stopped so enabling never flags at once
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= COUNT_PRESET;
        end else begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            presc_reg <= PRESC_ZERO;
        end else if (presc_clr) begin
            presc_reg <= PRESC_ZERO;
        end else begin
            presc_reg <= presc_inc;
        end
    end

    // rate latched only at reload so a running period never
    // changes length midway
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            presc_last_reg <= PRESC_LAST_1;
        end else if (reload) begin
            presc_last_reg <= presc_last(rate_sel);
        end
    end

    // flags and interrupt; set wins over clear
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // status bits cleared by a read; an event in that cycle survives
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_st_reg <= IRQ_RESET;
        end else begin
            irq_st_reg <= irq_st_next;
        end
    end

    // irq registered so the pin never glitches while status settles
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |irq_pend;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_clr_reg <= 1'b0;
        end else begin
            acc_clr_reg <= force_latch;
        end
    end

    // holding registers, one per capture channel
    // channels come from logic on this clock, so no synchroniser
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch++) begin : g_hold
            wire logic [15:0] cap_w = capture_chan_in[ch*16 +: 16];
            wire logic [7:0]  acc_w = pulse_acc_in[ch*8 +: 8];
            always_ff @(posedge ref_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    hold_cap_reg[ch] <= COUNT_ZERO;
                    hold_acc_reg[ch] <= BYTE_RESET;
                end else if (force_latch) begin
                    hold_cap_reg[ch] <= cap_w;
                    hold_acc_reg[ch] <= acc_w;
                end
            end
        end
    endgenerate

    assign wb_ack_out          = ack_reg;
    assign wb_dat_out          = dat_reg;
    assign irq_out             = irq_reg;
    assign pulse_acc_clear_out = acc_clr_reg;

endmodule
`default_nettype wire

// file: hw/mdc_pkg.sv
package mdc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'h26;
    localparam logic [7:0] IDX_FLAG    = 8'h27;
    localparam logic [7:0] IDX_LOAD    = 8'h28;
    localparam logic [7:0] IDX_COUNT   = 8'h29;
    localparam logic [7:0] IDX_CAPSYS  = 8'h2a;
    localparam logic [7:0] IDX_IRQ_ST  = 8'h2b;
    localparam logic [7:0] IDX_IRQ_MSK = 8'h2c;
    localparam logic [7:0] IDX_HOLD0   = 8'h30;
    localparam int         NUM_CHAN    = 4;
    localparam int         ADDR_LSB    = 2;

    // control field positions
    localparam int CTL_FORCE_LATCH = 4;
    localparam int CTL_FORCE_LOAD  = 3;
    localparam int CTL_ENABLE      = 2;
    localparam int CTL_PRESC_HI    = 1;
    localparam int CTL_PRESC_LO    = 0;
    // capture system control field positions
    localparam int CAP_LATCH_MODE  = 0;
    localparam int CAP_BUFFER_EN   = 1;
    localparam int CAP_PRECISION   = 2;
    // flag and interrupt bit positions
    localparam int FLG_ZERO        = 7;
    localparam int IRQ_ZERO        = 0;
    localparam int IRQ_LATCH       = 1;

    localparam logic [15:0] COUNT_PRESET  = 16'hffff;
    localparam logic [15:0] COUNT_ZERO    = 16'h0000;
    localparam logic [15:0] COUNT_ONE     = 16'h0001;
    localparam logic [15:0] LOAD_RESET    = 16'hffff;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    localparam logic [1:0]  IRQ_RESET     = 2'h0;
    localparam logic [3:0]  PRESC_ZERO    = 4'h0;
    localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

    // prescaler terminal counts for divide by 1, 4, 8, 16
    localparam logic [3:0]  PRESC_LAST_1  = 4'h0;
    localparam logic [3:0]  PRESC_LAST_4  = 4'h3;
    localparam logic [3:0]  PRESC_LAST_8  = 4'h7;
    localparam logic [3:0]  PRESC_LAST_16 = 4'hf;
endpackage
